// File: hw/cpurf_core_regs.v
// cpu register file, flags, program counter and operand address generator
//
// Contract
// - sixteen byte registers or eight word registers share one storage
// - addresses read whole words; data writes whole word or either byte
// - word register seven is the stack pointer, adjusted on calls and interrupts
// - word program counter; fetch by word; lowest bit always zero
// - flag bit 7 masks non-nmi interrupts; set on reset and interrupt entry
// - flag bits 6 and 4 are free user storage only
// - half-carry from bit 3 for bytes, bit 11 for words
// - negative flag takes result msb
// - zero flag set on zero result, cleared otherwise
// - overflow flag set on arithmetic overflow, cleared otherwise; word negate takes it from the alu_a and alu_b sign formula instead
// - carry flag: add/sub carry, shifted-out bit, bit accumulator
// - flags loadable, storable, and modifiable by and, or, xor
// - reset loads pc from vector, sets mask, leaves others undefined
// - register direct operand is a byte except listed word instructions
// - register indirect uses full register word as address
// - displacement small_constant_add second word to register; word address even
// - post-increment accesses then small_constant_add 1 or 2
// - pre-decrement subtracts 1 or 2 then accesses
// - short absolute forces upper eight address bits to ones
// - full sixteen-bit absolute for moves, jumps and calls
// - odd word and branch addresses drop lowest bit silently
// - pc-relative small_constant_add sign-extended byte displacement to pc
// - memory indirect reads target word from lowest page
`timescale 1ns/1ns
`include "cpurf_map.vh"

module cpurf_core_regs #(
	parameter NWORDS = 8,
	parameter AW = 3
) (
	// clock and reset
	input wire clk,
	input wire rst,
	// reset vector from memory bus
	input wire [15:0] reset_vector,
	// program counter control
	input wire pc_advance,
	input wire pc_load,
	input wire [15:0] pc_load_value,
	input wire pc_rel_branch,
	input wire [7:0] pc_rel_disp,
	// data register access
	input wire [AW-1:0] reg_idx,
	input wire reg_hi_sel,
	input wire reg_word,
	input wire reg_wr,
	input wire [15:0] reg_wr_data,
	// stack pointer adjust
	input wire sp_push,
	input wire sp_pop,
	// address generator request
	input wire ea_start,
	input wire [2:0] ea_mode,
	input wire [AW-1:0] ea_reg_idx,
	input wire ea_word,
	input wire [15:0] ea_ext,
	// flag control
	input wire [2:0] flag_op,
	input wire [7:0] flag_operand,
	input wire [7:0] flag_update_mask,
	input wire [2:0] alu_op,
	input wire alu_word,
	input wire [15:0] alu_a,
	input wire [15:0] alu_b,
	input wire alu_shift_out,
	input wire alu_bit_acc,
	input wire int_entry,
	// outputs
	output reg [15:0] pc_r,
	output reg [15:0] fetch_addr_r,
	output reg [7:0] condition_flags_r,
	output reg int_masked_r,
	output reg [15:0] reg_rd_data_r,
	output reg [15:0] stack_pointer_register_r,
	output reg [15:0] ea_addr_r,
	output reg ea_valid_r,
	output reg ea_mem_indirect_r,
	output reg [15:0] alu_result_r
);

	// ------------------------------------------------------------
	// functions
	// ------------------------------------------------------------
	function [15:0] word_align;
		input [15:0] a;
		begin
			word_align = {a[15:1], 1'b0};
		end
	endfunction

	function [15:0] step_of;
		input w;
		begin
			step_of = w ? `CPURF_STEP_WORD : `CPURF_STEP_BYTE;
		end
	endfunction

	// ------------------------------------------------------------
	// register storage
	// ------------------------------------------------------------
	reg [AW-1:0] mem_wr_idx;
	reg mem_wr_hi;
	reg mem_wr_lo;
	reg [15:0] mem_wr_data;
	wire [15:0] rd_a_data;
	wire [15:0] rd_b_data;
	reg [15:0] sp_r;
	reg sp_valid_r;
	wire [AW-1:0] sp_idx = `CPURF_SP_IDX;

	cpurf_gpr_mem #(
		.NWORDS(NWORDS),
		.AW(AW)
	) u_mem (
		.clk(clk),
		.wr_idx(mem_wr_idx),
		.wr_hi(mem_wr_hi),
		.wr_lo(mem_wr_lo),
		.wr_data(mem_wr_data),
		.rd_a_idx(reg_idx),
		.rd_a_data(rd_a_data),
		.rd_b_idx(ea_reg_idx),
		.rd_b_data(rd_b_data)
	);

	// ------------------------------------------------------------
	// address generator state machine
	// ------------------------------------------------------------
	localparam EA_IDLE = 2'h0;
	localparam EA_READ = 2'h1;
	localparam EA_CALC = 2'h2;

	reg [1:0] ea_state_r;
	reg [2:0] ea_mode_r;
	reg [AW-1:0] ea_idx_r;
	reg ea_word_r;
	reg [15:0] ea_ext_r;
	reg [15:0] base_r;
	reg [15:0] ea_addr_nxt;
	reg ptr_wr;
	reg [15:0] ptr_val;

	always @* begin
		ea_addr_nxt = base_r;
		ptr_wr = 1'b0;
		ptr_val = base_r;
		case (ea_mode_r)
			`CPURF_AM_REG: ea_addr_nxt = base_r;
			`CPURF_AM_IND: ea_addr_nxt = base_r;
			`CPURF_AM_DISP: ea_addr_nxt = base_r + ea_ext_r;
			`CPURF_AM_POSTINC: begin
				ea_addr_nxt = base_r;
				ptr_wr = 1'b1;
				ptr_val = base_r + step_of(ea_word_r);
			end
			`CPURF_AM_PREDEC: begin
				ptr_val = base_r - step_of(ea_word_r);
				ptr_wr = 1'b1;
				ea_addr_nxt = ptr_val;
			end
			`CPURF_AM_ABS8: ea_addr_nxt = {`CPURF_TOP_PAGE, ea_ext_r[7:0]};
			`CPURF_AM_ABS16: ea_addr_nxt = ea_ext_r;
			`CPURF_AM_MEMIND: ea_addr_nxt = word_align({`CPURF_LOW_PAGE, ea_ext_r[7:0]});
			default: ea_addr_nxt = base_r;
		endcase
		if (ea_word_r) begin
			ea_addr_nxt = word_align(ea_addr_nxt);
		end
	end

	always @(posedge clk) begin
		if (rst) begin
			ea_state_r <= EA_IDLE;
			ea_mode_r <= `CPURF_AM_REG;
			ea_idx_r <= {AW{1'b0}};
			ea_word_r <= 1'b0;
			ea_ext_r <= 16'h0000;
			base_r <= 16'h0000;
			ea_addr_r <= 16'h0000;
			ea_valid_r <= 1'b0;
			ea_mem_indirect_r <= 1'b0;
		end else begin
			ea_valid_r <= 1'b0;
			case (ea_state_r)
				EA_IDLE: begin
					if (ea_start) begin
						ea_mode_r <= ea_mode;
						ea_idx_r <= ea_reg_idx;
						ea_word_r <= ea_word;
						ea_ext_r <= ea_ext;
						ea_state_r <= EA_READ;
					end
				end
				EA_READ: begin
					// full word read for address use
					base_r <= rd_b_data;
					ea_state_r <= EA_CALC;
				end
				EA_CALC: begin
					ea_addr_r <= ea_addr_nxt;
					ea_valid_r <= 1'b1;
					ea_mem_indirect_r <= (ea_mode_r == `CPURF_AM_MEMIND);
					ea_state_r <= EA_IDLE;
				end
				default: ea_state_r <= EA_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// register write arbitration
	// ------------------------------------------------------------
	wire ea_ptr_wr = (ea_state_r == EA_CALC) && ptr_wr;
	wire [15:0] sp_step_val = sp_push ? (sp_r - `CPURF_STEP_WORD) : (sp_r + `CPURF_STEP_WORD);

	always @* begin
		mem_wr_idx = reg_idx;
		mem_wr_hi = 1'b0;
		mem_wr_lo = 1'b0;
		mem_wr_data = reg_wr_data;
		if (ea_ptr_wr) begin
			mem_wr_idx = ea_idx_r;
			mem_wr_hi = 1'b1;
			mem_wr_lo = 1'b1;
			mem_wr_data = ptr_val;
		end else if (sp_push || sp_pop) begin
			mem_wr_idx = sp_idx;
			mem_wr_hi = 1'b1;
			mem_wr_lo = 1'b1;
			mem_wr_data = sp_step_val;
		end else if (reg_wr) begin
			mem_wr_hi = reg_word | reg_hi_sel;
			mem_wr_lo = reg_word | ~reg_hi_sel;
			mem_wr_data = reg_word ? reg_wr_data : {reg_wr_data[7:0], reg_wr_data[7:0]};
		end
	end

	// shadow copy of the stack pointer for the dedicated output
	always @(posedge clk) begin
		if (rst) begin
			sp_valid_r <= 1'b0;
			sp_r <= 16'h0000;
		end else if (mem_wr_idx == sp_idx && mem_wr_hi && mem_wr_lo) begin
			sp_r <= mem_wr_data;
			sp_valid_r <= 1'b1;
		end else if (mem_wr_idx == sp_idx && mem_wr_hi) begin
			sp_r <= {mem_wr_data[15:8], sp_r[7:0]};
		end else if (mem_wr_idx == sp_idx && mem_wr_lo) begin
			sp_r <= {sp_r[15:8], mem_wr_data[7:0]};
		end
	end

	always @(posedge clk) begin
		if (rst) begin
			stack_pointer_register_r <= 16'h0000;
			reg_rd_data_r <= 16'h0000;
		end else begin
			stack_pointer_register_r <= word_align(sp_r);
			reg_rd_data_r <= reg_word ? rd_a_data :
				(reg_hi_sel ? {8'h00, rd_a_data[15:8]} : {8'h00, rd_a_data[7:0]});
		end
	end

	// ------------------------------------------------------------
	// program counter
	// ------------------------------------------------------------
	wire [15:0] rel_target = pc_r + {{8{pc_rel_disp[7]}}, pc_rel_disp};

	// vector fetch happens on the first cycle after reset release
	reg boot_r;
	always @(posedge clk) begin
		if (rst) begin
			boot_r <= 1'b1;
		end else begin
			boot_r <= 1'b0;
		end
	end

	always @(posedge clk) begin
		if (rst) begin
			pc_r <= 16'h0000;
			fetch_addr_r <= 16'h0000;
		end else begin
			if (pc_load) begin
				pc_r <= word_align(pc_load_value);
			end else if (boot_r) begin
				pc_r <= word_align(reset_vector);
			end else if (pc_rel_branch) begin
				pc_r <= word_align(rel_target);
			end else if (pc_advance) begin
				pc_r <= pc_r + `CPURF_STEP_WORD;
			end
			fetch_addr_r <= word_align(pc_r);
		end
	end

	// ------------------------------------------------------------
	// alu flag computation
	// ------------------------------------------------------------
	reg [16:0] sum;
	reg [12:0] sum12;
	reg [4:0] sum4;
	reg [15:0] res;
	reg [7:0] alu_flags;
	reg is_sub;
	reg ovf;

	always @* begin
		is_sub = (alu_op == `CPURF_ALU_SUB) || (alu_op == `CPURF_ALU_CMP) || (alu_op == `CPURF_ALU_NEG);
		sum = 17'h00000;
		sum12 = 13'h0000;
		sum4 = 5'h00;
		res = alu_a;
		ovf = 1'b0;
		alu_flags = condition_flags_r;
		case (alu_op)
			`CPURF_ALU_ADD, `CPURF_ALU_SUB, `CPURF_ALU_CMP, `CPURF_ALU_NEG: begin
				if (alu_op == `CPURF_ALU_NEG) begin
					sum = {1'b0, 16'h0000} - {1'b0, alu_a};
					sum12 = {1'b0, 12'h000} - {1'b0, alu_a[11:0]};
					sum4 = {1'b0, 4'h0} - {1'b0, alu_a[3:0]};
				end else if (is_sub) begin
					sum = {1'b0, alu_a} - {1'b0, alu_b};
					sum12 = {1'b0, alu_a[11:0]} - {1'b0, alu_b[11:0]};
					sum4 = {1'b0, alu_a[3:0]} - {1'b0, alu_b[3:0]};
				end else begin
					sum = {1'b0, alu_a} + {1'b0, alu_b};
					sum12 = {1'b0, alu_a[11:0]} + {1'b0, alu_b[11:0]};
					sum4 = {1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]};
				end
				res = sum[15:0];
				alu_flags[`CPURF_FLAG_H] = alu_word ? sum12[12] : sum4[4];
				if (alu_word) begin
					ovf = is_sub ? ((alu_a[15] ^ alu_b[15]) & (alu_a[15] ^ res[15]))
						: (~(alu_a[15] ^ alu_b[15]) & (alu_a[15] ^ res[15]));
					alu_flags[`CPURF_FLAG_C] = sum[16];
				end else begin
					ovf = is_sub ? ((alu_a[7] ^ alu_b[7]) & (alu_a[7] ^ res[7]))
						: (~(alu_a[7] ^ alu_b[7]) & (alu_a[7] ^ res[7]));
					// negate is zero minus a, so b takes no part in the byte borrow
					alu_flags[`CPURF_FLAG_C] = (alu_op == `CPURF_ALU_NEG) ? (alu_a[8] ^ res[8])
						: (alu_a[8] ^ alu_b[8] ^ res[8]);
				end
				if (alu_op == `CPURF_ALU_NEG && !alu_word) begin
					ovf = (alu_a[7:0] == 8'h80);
				end
				alu_flags[`CPURF_FLAG_V] = ovf;
			end
			`CPURF_ALU_LOGIC: res = alu_b;
			`CPURF_ALU_SHIFT: begin
				res = alu_b;
				alu_flags[`CPURF_FLAG_C] = alu_shift_out;
			end
			`CPURF_ALU_BIT: alu_flags[`CPURF_FLAG_C] = alu_bit_acc;
			default: res = alu_a;
		endcase
		alu_flags[`CPURF_FLAG_N] = alu_word ? res[15] : res[7];
		alu_flags[`CPURF_FLAG_Z] = alu_word ? (res == 16'h0000) : (res[7:0] == 8'h00);
	end

	// ------------------------------------------------------------
	// flag register
	// ------------------------------------------------------------
	reg [7:0] flags_nxt;
	localparam [7:0] HW_ALU_BITS = 8'h2f;

	always @* begin
		flags_nxt = condition_flags_r;
		case (flag_op)
			`CPURF_FOP_LOAD: flags_nxt = flag_operand;
			`CPURF_FOP_AND: flags_nxt = condition_flags_r & flag_operand;
			`CPURF_FOP_OR: flags_nxt = condition_flags_r | flag_operand;
			`CPURF_FOP_XOR: flags_nxt = condition_flags_r ^ flag_operand;
			`CPURF_FOP_ALU: begin
				// user bits and mask never touched by arithmetic
				flags_nxt = (condition_flags_r & ~(flag_update_mask & HW_ALU_BITS)) |
					(alu_flags & flag_update_mask & HW_ALU_BITS);
			end
			default: flags_nxt = condition_flags_r;
		endcase
		if (int_entry) begin
			flags_nxt[`CPURF_FLAG_I] = 1'b1;
		end
	end

	always @(posedge clk) begin
		if (rst) begin
			condition_flags_r <= `CPURF_FLAGS_RST;
			int_masked_r <= 1'b1;
			alu_result_r <= 16'h0000;
		end else begin
			condition_flags_r <= flags_nxt;
			int_masked_r <= flags_nxt[`CPURF_FLAG_I];
			alu_result_r <= res;
		end
	end

endmodule // cpurf_core_regs

// File: common/cpurf_map.vh
// constants for the cpu register file and address generator
`ifndef CPURF_MAP_VH
`define CPURF_MAP_VH

// flag bit positions
`define CPURF_FLAG_C 0
`define CPURF_FLAG_V 1
`define CPURF_FLAG_Z 2
`define CPURF_FLAG_N 3
`define CPURF_FLAG_U4 4
`define CPURF_FLAG_H 5
`define CPURF_FLAG_U6 6
`define CPURF_FLAG_I 7

// flag reset value: only the mask is defined
`define CPURF_FLAGS_RST 8'h80

// stack pointer word index
`define CPURF_SP_IDX 3'h7

// address modes
`define CPURF_AM_REG 3'h0
`define CPURF_AM_IND 3'h1
`define CPURF_AM_DISP 3'h2
`define CPURF_AM_POSTINC 3'h3
`define CPURF_AM_PREDEC 3'h4
`define CPURF_AM_ABS8 3'h5
`define CPURF_AM_ABS16 3'h6
`define CPURF_AM_MEMIND 3'h7

// upper byte forced for short absolute, lowest page for memory indirect
`define CPURF_TOP_PAGE 8'hff
`define CPURF_LOW_PAGE 8'h00

// flag register operations
`define CPURF_FOP_NONE 3'h0
`define CPURF_FOP_LOAD 3'h1
`define CPURF_FOP_AND 3'h2
`define CPURF_FOP_OR 3'h3
`define CPURF_FOP_XOR 3'h4
`define CPURF_FOP_ALU 3'h5

// alu operations
`define CPURF_ALU_ADD 3'h0
`define CPURF_ALU_SUB 3'h1
`define CPURF_ALU_NEG 3'h2
`define CPURF_ALU_CMP 3'h3
`define CPURF_ALU_LOGIC 3'h4
`define CPURF_ALU_SHIFT 3'h5
`define CPURF_ALU_BIT 3'h6

// pointer steps
`define CPURF_STEP_BYTE 16'h0001
`define CPURF_STEP_WORD 16'h0002

`endif

// File: hw/cpurf_gpr_mem.v
// general register storage: eight words, byte-writable halves
`timescale 1ns/1ns
`include "cpurf_map.vh"

module cpurf_gpr_mem #(
	parameter NWORDS = 8,
	parameter AW = 3
) (
	// clock
	input wire clk,
	// write side
	input wire [AW-1:0] wr_idx,
	input wire wr_hi,
	input wire wr_lo,
	input wire [15:0] wr_data,
	// registered read ports
	input wire [AW-1:0] rd_a_idx,
	output reg [15:0] rd_a_data,
	input wire [AW-1:0] rd_b_idx,
	output reg [15:0] rd_b_data
);

	reg [7:0] hi_mem [0:NWORDS-1];
	reg [7:0] lo_mem [0:NWORDS-1];

	// no reset: register contents are undefined after reset
	always @(posedge clk) begin
		if (wr_hi) begin
			hi_mem[wr_idx] <= wr_data[15:8];
		end
		if (wr_lo) begin
			lo_mem[wr_idx] <= wr_data[7:0];
		end
		rd_a_data <= {hi_mem[rd_a_idx], lo_mem[rd_a_idx]};
		rd_b_data <= {hi_mem[rd_b_idx], lo_mem[rd_b_idx]};
	end

endmodule // cpurf_gpr_mem

// File: bench/cpurf_core_regs_props.sv
// concurrent checks on the register file and address generator ports
`timescale 1ns/1ns
`include "cpurf_map.vh"

module cpurf_core_regs_props (
	// clock and reset
	input wire clk,
	input wire rst,
	// controls
	input wire pc_load,
	input wire [15:0] pc_load_value,
	input wire pc_rel_branch,
	input wire [7:0] pc_rel_disp,
	input wire ea_start,
	input wire [2:0] ea_mode,
	input wire ea_word,
	input wire [15:0] ea_ext,
	input wire [2:0] flag_op,
	input wire [7:0] flag_operand,
	input wire int_entry,
	// outputs watched
	input wire [15:0] pc_r,
	input wire [15:0] fetch_addr_r,
	input wire [7:0] condition_flags_r,
	input wire [15:0] ea_addr_r,
	input wire ea_valid_r,
	input wire ea_mem_indirect_r
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	wire [15:0] rel_sum = pc_r + {{8{pc_rel_disp[7]}}, pc_rel_disp};

	a_fetch_even: assert property (fetch_addr_r == ($past(pc_r) & 16'hfffe))
		else $error("fetch address not the even program counter");
	a_pc_load: assert property (pc_load |=> ((pc_r ^ $past(pc_load_value)) & 16'hfffe) == 16'h0000)
		else $error("program counter load missed");
	a_pc_rel: assert property (pc_rel_branch && !pc_load |=> ((pc_r ^ $past(rel_sum)) & 16'hfffe) == 16'h0000)
		else $error("relative branch target wrong");
	a_mask_entry: assert property (int_entry |=> condition_flags_r[`CPURF_FLAG_I])
		else $error("mask not set on interrupt entry");
	a_flag_load: assert property (flag_op == `CPURF_FOP_LOAD && !int_entry |=> condition_flags_r == $past(flag_operand))
		else $error("flag load wrong");
	a_user_hold: assert property (flag_op == `CPURF_FOP_ALU |=> ((condition_flags_r ^ $past(condition_flags_r)) & 8'h50) == 8'h00)
		else $error("user flag bits changed by alu");
	a_ea_answer: assert property (ea_start |-> ##3 ea_valid_r)
		else $error("address result late");
	a_abs8_page: assert property (ea_start && ea_mode == `CPURF_AM_ABS8 |-> ##3 ea_addr_r == (16'hff00 | ($past(ea_ext, 3) & 16'h00ff)))
		else $error("short absolute not on top page");
	a_abs16_addr: assert property (ea_start && ea_mode == `CPURF_AM_ABS16 |-> ##3 ea_addr_r == ($past(ea_ext, 3) & ($past(ea_word, 3) ? 16'hfffe : 16'hffff)))
		else $error("absolute address wrong");
	a_mem_ind: assert property (ea_start && ea_mode == `CPURF_AM_MEMIND |-> ##3 ea_mem_indirect_r && ea_addr_r == ($past(ea_ext, 3) & 16'h00fe))
		else $error("memory indirect pointer wrong");
endmodule // cpurf_core_regs_props

// File: bench/cpurf_bus_model.sv
// memory bus and interrupt source model
`timescale 1ns/1ns

module cpurf_bus_model #(
	parameter [15:0] VECTOR = 16'h0100
) (
	// clock and reset
	input wire clk,
	input wire rst,
	// from the block and bench
	input wire ea_valid_r,
	input wire ea_mem_indirect_r,
	input wire [15:0] ea_addr_r,
	input wire irq_req,
	// to the block and bench
	output wire [15:0] reset_vector,
	output reg int_entry,
	output reg [15:0] target_word
);
	assign reset_vector = VECTOR;
	always @(posedge clk) begin
		int_entry <= !rst && irq_req;
		if (rst)
			target_word <= 16'h0000;
		else if (ea_valid_r && ea_mem_indirect_r)
			target_word <= {8'h40, ea_addr_r[7:0]};
	end
endmodule // cpurf_bus_model

// File: bench/cpurf_core_regs_tb.sv
// self-checking bench for the register file and address generator
`timescale 1ns/1ns
`include "cpurf_map.vh"

module cpurf_core_regs_tb;
	localparam [15:0] VEC = 16'h0100;
	reg clk = 1'b0, rst = 1'b1, irq_req = 1'b0;
	reg pc_advance = 1'b0, pc_load = 1'b0, pc_rel_branch = 1'b0;
	reg [15:0] pc_load_value = 16'h0000, reg_wr_data = 16'h0000, ea_ext = 16'h0000;
	reg [15:0] alu_a = 16'h0000, alu_b = 16'h0000;
	reg [7:0] pc_rel_disp = 8'h00, flag_operand = 8'h00, flag_update_mask = 8'h00;
	reg [2:0] reg_idx = 3'h0, ea_reg_idx = 3'h0, ea_mode = 3'h0, flag_op = 3'h0, alu_op = 3'h0;
	reg reg_hi_sel = 1'b0, reg_word = 1'b0, reg_wr = 1'b0, sp_push = 1'b0, sp_pop = 1'b0;
	reg ea_start = 1'b0, ea_word = 1'b0, alu_word = 1'b0, alu_shift_out = 1'b0, alu_bit_acc = 1'b0;
	wire [15:0] reset_vector, target_word, pc_r, fetch_addr_r, reg_rd_data_r, stack_pointer_register_r;
	wire [15:0] ea_addr_r, alu_result_r;
	wire [7:0] condition_flags_r;
	wire int_entry, int_masked_r, ea_valid_r, ea_mem_indirect_r;
	integer failures = 0, check_count = 0, n;

	cpurf_core_regs i_dut (.*);
	cpurf_bus_model #(.VECTOR(VEC)) i_bus (.*);

	always #5 clk = ~clk;

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task tick;
		begin
			@(posedge clk);
			#1;
		end
	endtask
	task check(input [15:0] seen, input [15:0] exp);
		begin
			check_count = check_count + 1;
			if (seen !== exp) begin
				failures = failures + 1;
				$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task wreg(input [2:0] idx, input hi, input w, input [15:0] d);
		begin
			reg_idx = idx; reg_hi_sel = hi; reg_word = w; reg_wr_data = d; reg_wr = 1'b1;
			tick;
			reg_wr = 1'b0;
		end
	endtask
	task rreg(input [2:0] idx, input hi, input w, input [15:0] exp);
		begin
			reg_idx = idx; reg_hi_sel = hi; reg_word = w;
			tick;
			tick;
			check(reg_rd_data_r, exp);
		end
	endtask
	task ea(input [2:0] m, input [2:0] idx, input w, input [15:0] x, input [15:0] exp);
		begin
			ea_mode = m; ea_reg_idx = idx; ea_word = w; ea_ext = x; ea_start = 1'b1;
			tick;
			ea_start = 1'b0;
			n = 0;
			while (ea_valid_r !== 1'b1 && n < 8) begin
				tick;
				n = n + 1;
			end
			check(n[15:0], 16'h0002);
			check(ea_addr_r, exp);
		end
	endtask
	task fop(input [2:0] op, input [7:0] v, input [7:0] exp);
		begin
			flag_op = op; flag_operand = v;
			tick;
			flag_op = `CPURF_FOP_NONE;
			tick;
			check({8'h00, condition_flags_r}, {8'h00, exp});
		end
	endtask
	task alu(input [2:0] op, input w, input [15:0] a, input [15:0] b, input [7:0] mask, input cr,
		input [15:0] res, input [7:0] exp);
		begin
			alu_op = op; alu_word = w; alu_a = a; alu_b = b; flag_update_mask = mask;
			fop(`CPURF_FOP_ALU, 8'h00, exp);
			if (cr)
				check(alu_result_r & (w ? 16'hffff : 16'h00ff), res);
		end
	endtask
	task pcs(input l, input r, input a, input [7:0] d, input [15:0] exp);
		begin
			pc_load = l; pc_rel_branch = r; pc_advance = a; pc_rel_disp = d;
			tick;
			pc_load = 1'b0; pc_rel_branch = 1'b0; pc_advance = 1'b0;
			check(pc_r, exp);
		end
	endtask
	task give_verdict;
		begin
			$display("comparisons %0d mismatches %0d", check_count, failures);
			if (failures == 0 && check_count > 0)
				$display("Test passed");
			else
				$display("Test failed");
			$finish;
		end
	endtask

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		repeat (10) @(posedge clk);
		#1 rst = 1'b0;
		check({8'h00, condition_flags_r}, 16'h0080);
		check({15'h0, int_masked_r}, 16'h0001);
		pc_load_value = reset_vector;
		pcs(1, 0, 0, 8'h00, VEC);
		pcs(0, 0, 1, 8'h00, VEC + 16'h0002);
		pcs(0, 1, 0, 8'hfe, VEC);
		pcs(0, 1, 0, 8'h7f, 16'h017e);
		tick;
		check(fetch_addr_r, 16'h017e);
		$display("program counter test done");
		wreg(3'h2, 0, 1, 16'h1234);
		wreg(3'h2, 1, 0, 16'h00ab);
		rreg(3'h2, 0, 1, 16'hab34);
		rreg(3'h2, 0, 0, 16'h0034);
		rreg(3'h2, 1, 0, 16'h00ab);
		wreg(3'h7, 0, 1, 16'h0400);
		sp_push = 1'b1;
		tick;
		sp_push = 1'b0;
		tick;
		check(stack_pointer_register_r, 16'h03fe);
		sp_pop = 1'b1;
		tick;
		sp_pop = 1'b0;
		rreg(3'h7, 0, 1, 16'h0400);
		$display("register file test done");
		wreg(3'h1, 0, 1, 16'h2000);
		ea(`CPURF_AM_IND, 3'h1, 0, 16'h0000, 16'h2000);
		ea(`CPURF_AM_DISP, 3'h1, 0, 16'h0010, 16'h2010);
		ea(`CPURF_AM_POSTINC, 3'h1, 1, 16'h0000, 16'h2000);
		rreg(3'h1, 0, 1, 16'h2002);
		ea(`CPURF_AM_POSTINC, 3'h1, 0, 16'h0000, 16'h2002);
		rreg(3'h1, 0, 1, 16'h2003);
		ea(`CPURF_AM_PREDEC, 3'h1, 0, 16'h0000, 16'h2002);
		ea(`CPURF_AM_PREDEC, 3'h1, 1, 16'h0000, 16'h2000);
		rreg(3'h1, 0, 1, 16'h2000);
		ea(`CPURF_AM_ABS8, 3'h0, 0, 16'h0034, 16'hff34);
		ea(`CPURF_AM_ABS16, 3'h0, 0, 16'h1235, 16'h1235);
		ea(`CPURF_AM_ABS16, 3'h0, 1, 16'h1235, 16'h1234);
		ea(`CPURF_AM_MEMIND, 3'h0, 0, 16'h0021, 16'h0020);
		check({15'h0, ea_mem_indirect_r}, 16'h0001);
		tick;
		pc_load_value = target_word;
		pcs(1, 0, 0, 8'h00, 16'h4020);
		$display("address generator test done");
		fop(`CPURF_FOP_LOAD, 8'h50, 8'h50);
		alu(`CPURF_ALU_ADD, 0, 16'h000f, 16'h0001, 8'h2f, 1, 16'h0010, 8'h70);
		alu(`CPURF_ALU_ADD, 0, 16'h00ff, 16'h0001, 8'h2f, 1, 16'h0000, 8'h75);
		alu(`CPURF_ALU_ADD, 0, 16'h007f, 16'h0001, 8'h2f, 1, 16'h0080, 8'h7a);
		alu(`CPURF_ALU_ADD, 1, 16'h0fff, 16'h0001, 8'h2f, 1, 16'h1000, 8'h70);
		alu(`CPURF_ALU_SUB, 0, 16'h0010, 16'h0001, 8'h2f, 1, 16'h000f, 8'h70);
		alu(`CPURF_ALU_SUB, 0, 16'h0000, 16'h0001, 8'h2f, 1, 16'h00ff, 8'h79);
		alu(`CPURF_ALU_NEG, 0, 16'h0001, 16'h0001, 8'h2f, 1, 16'h00ff, 8'h79);
		alu(`CPURF_ALU_CMP, 1, 16'h8000, 16'h0001, 8'h2f, 0, 16'h0000, 8'h72);
		alu_shift_out = 1'b1;
		alu(`CPURF_ALU_SHIFT, 0, 16'h0000, 16'h0000, 8'h01, 0, 16'h0000, 8'h73);
		alu(`CPURF_ALU_BIT, 0, 16'h0000, 16'h0000, 8'h01, 0, 16'h0000, 8'h72);
		alu(`CPURF_ALU_LOGIC, 0, 16'h0000, 16'h0000, 8'h00, 0, 16'h0000, 8'h72);
		fop(`CPURF_FOP_AND, 8'hf0, 8'h70);
		fop(`CPURF_FOP_OR, 8'h0f, 8'h7f);
		fop(`CPURF_FOP_XOR, 8'hff, 8'h80);
		fop(`CPURF_FOP_LOAD, 8'h00, 8'h00);
		check({15'h0, int_masked_r}, 16'h0000);
		irq_req = 1'b1;
		tick;
		irq_req = 1'b0;
		tick;
		tick;
		check({8'h00, condition_flags_r}, 16'h0080);
		check({15'h0, int_masked_r}, 16'h0001);
		$display("flag test done");
		fop(`CPURF_FOP_LOAD, 8'h00, 8'h00);
		rst = 1'b1;
		tick;
		tick;
		rst = 1'b0;
		check({8'h00, condition_flags_r}, 16'h0080);
		check(pc_r, 16'h0000);
		tick;
		check(pc_r, VEC);
		$display("second reset test done");
		give_verdict;
	end

	initial begin
		#100000;
		failures = failures + 1;
		give_verdict;
	end
endmodule // cpurf_core_regs_tb

bind cpurf_core_regs cpurf_core_regs_props i_props (.*);
